// [verilog/starter_params.svh]
/*
  Holds the register offsets, field positions, reset values and timing counts of
  the soft starter supervisor. Assumes a 50 MHz control clock and APB access.
*/
`ifndef STARTER_PARAMS_SVH
`define STARTER_PARAMS_SVH

// =====================================================================
// register map (byte addresses)
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_IRQ_STAT 12'h008
`define OFF_IRQ_MASK 12'h00c
`define OFF_FAULT 12'h010

// =====================================================================
// control register fields
`define CTRL_RAMPDOWN_EN 0
`define CTRL_FORCE_RUNMODE 1
`define CTRL_RESET_VALUE 32'h00000000

// =====================================================================
// interrupt status bits
`define IRQ_TRIP 0
`define IRQ_CLEARED 1
`define IRQ_BYPASS 2
`define IRQ_WIDTH 3

// =====================================================================
// timing, in milliseconds as printed, and clock rate
// unsigned so the 60 s count stays inside 32 bits without a signed overflow
`define CLK_HZ 32'h02faf080
`define OVERLOAD_RESET_MS 60000
`define DEVICE_RESET_MS 30000
`define TEST_HOLD_MS 5000
`define SHORT_PRESS_MS 1000
`define OVERLOAD_RESET_CYC ((`OVERLOAD_RESET_MS / 1000) * `CLK_HZ)
`define DEVICE_RESET_CYC ((`DEVICE_RESET_MS / 1000) * `CLK_HZ)
`define TEST_HOLD_CYC ((`TEST_HOLD_MS / 1000) * `CLK_HZ)
`define SHORT_PRESS_CYC ((`SHORT_PRESS_MS / 1000) * `CLK_HZ)

`endif

// [verilog/starter_pkg.sv]
/*
  Types shared by the soft starter supervisor files.
  Assumes the params header is included by each user.
*/
package starter_pkg;

  // =====================================================================
  // acknowledge policy and motor sequence
  typedef enum logic [1:0] {POL_AUTO, POL_MANUAL, POL_REMOTE} policy_e;
  typedef enum logic [1:0] {MOT_OFF, MOT_RAMP, MOT_BYPASS, MOT_STOP} motor_e;

endpackage

// [verilog/sync_debounce.sv]
/*
  Two-flop synchroniser for one pin, followed by rise and fall detection.
  Assumes the pin is asynchronous to mclk.
*/
`timescale 1ns/1ps
module sync_debounce
  import starter_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // =====================================================================
  // s1 feeds only s2; edges are judged on s2 against s3
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.s2;
  assign rise = st.s2 & ~st.s3;
  assign fall = ~st.s2 & st.s3;

endmodule

// [verilog/motor_supervisor.sv]
/*
  Supervisory logic of a motor soft starter: fault acknowledge policy, automatic
  reset timers, trip test, start input handling, output contacts, APB registers.
  Assumes pushbuttons and start input are asynchronous pins; trip sources and
  ramp-up detection come from logic on mclk; rst_n follows control supply.
*/
`timescale 1ns/1ps
`include "starter_params.svh"
module motor_supervisor
  import starter_pkg::*;
#(
  parameter int unsigned OVERLOAD_CYC = `OVERLOAD_RESET_CYC,
  parameter int unsigned DEVICE_CYC = `DEVICE_RESET_CYC,
  parameter int unsigned TEST_CYC = `TEST_HOLD_CYC,
  parameter int unsigned SHORT_CYC = `SHORT_PRESS_CYC
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic startPin,
  input wire logic ackKeyPin,
  input wire logic policyKeyPin,
  input wire logic remoteAckPin,
  input wire logic overloadTrip,
  input wire logic deviceTrip,
  input wire logic rampUpDone,
  input wire logic rampDownDone,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic echoContact,
  output logic bypassedContact,
  output logic bypassRelay,
  output logic groupFaultContact,
  output logic overloadLed,
  output logic policyLed,
  output logic motorOn,
  output logic softStop,
  output logic irq
);

  typedef struct packed {
    policy_e policy;
    motor_e motor;
    logic runMode;
    logic faultOverload;
    logic faultDevice;
    logic [31:0] autoCnt;
    logic [31:0] holdCnt;
    logic testDone;
    logic bothSeen;
    logic rampDownEn;
    logic [`IRQ_WIDTH-1:0] irqStat;
    logic [`IRQ_WIDTH-1:0] irqMask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic echoContact;
    logic bypassedContact;
    logic bypassRelay;
    logic groupFaultContact;
    logic overloadLed;
    logic policyLed;
    logic motorOn;
    logic softStop;
    logic irq;
  } sup_s;

  sup_s st;
  sup_s next_st;

  logic startLvl;
  logic ackLvl;
  logic ackRise;
  logic ackFall;
  logic polLvl;
  logic polRise;
  logic remRise;

  // =====================================================================
  // pin synchronisers
  sync_debounce u_start (.mclk(mclk), .rst_n(rst_n), .pin(startPin),
    .level(startLvl), .rise(), .fall());
  sync_debounce u_ack (.mclk(mclk), .rst_n(rst_n), .pin(ackKeyPin),
    .level(ackLvl), .rise(ackRise), .fall(ackFall));
  sync_debounce u_pol (.mclk(mclk), .rst_n(rst_n), .pin(policyKeyPin),
    .level(polLvl), .rise(polRise), .fall());
  sync_debounce u_rem (.mclk(mclk), .rst_n(rst_n), .pin(remoteAckPin),
    .level(), .rise(remRise), .fall());

  // next policy in the key's cycle
  function automatic policy_e nextPolicy(input policy_e p);
    case (p)
      POL_AUTO: nextPolicy = POL_MANUAL;
      POL_MANUAL: nextPolicy = POL_REMOTE;
      default: nextPolicy = POL_AUTO;
    endcase
  endfunction

  // =====================================================================
  // all behaviour in one combinational pass
  always_comb begin
    logic faultAny;
    logic ackEvent;
    logic apbAccess;
    logic [`IRQ_WIDTH-1:0] evt;
    faultAny = 1'b0;
    ackEvent = 1'b0;
    apbAccess = 1'b0;
    evt = '0;
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;

    // both keys together change the contact function, not the policy
    if (ackLvl && polLvl && !st.bothSeen) begin
      next_st.runMode = ~st.runMode;
      next_st.bothSeen = 1'b1;
    end else if (!ackLvl && !polLvl) begin
      next_st.bothSeen = 1'b0;
    end
    if (polRise && !ackLvl && !st.bothSeen) begin
      next_st.policy = nextPolicy(st.policy);
    end

    // acknowledge key hold timer; a long hold is a trip test
    if (ackLvl && !st.bothSeen) begin
      if (st.holdCnt < TEST_CYC) begin
        next_st.holdCnt = st.holdCnt + 32'h1;
      end else if (!st.testDone) begin
        next_st.testDone = 1'b1;
        next_st.faultOverload = 1'b1;
        next_st.autoCnt = '0;
        evt[`IRQ_TRIP] = 1'b1;
      end
    end else begin
      next_st.holdCnt = '0;
      next_st.testDone = 1'b0;
    end

    // acknowledge sources gated by policy; a fault holds otherwise
    if (st.policy == POL_MANUAL && ackFall && !st.testDone && !st.bothSeen
        && st.holdCnt < SHORT_CYC) begin
      ackEvent = 1'b1;
    end
    if (st.policy == POL_REMOTE && remRise) begin
      ackEvent = 1'b1;
    end

    // auto timer runs from the trip; overload also waits out recovery
    if (st.faultOverload || st.faultDevice) begin
      if (st.autoCnt != 32'hffffffff) begin
        next_st.autoCnt = st.autoCnt + 32'h1;
      end
    end
    if (st.faultOverload && st.autoCnt >= OVERLOAD_CYC
        && (st.policy == POL_AUTO || ackEvent)) begin
      next_st.faultOverload = 1'b0;
    end else if (st.faultOverload && ackEvent && st.autoCnt >= OVERLOAD_CYC) begin
      next_st.faultOverload = 1'b0;
    end
    if (st.faultDevice && !st.faultOverload && st.autoCnt >= DEVICE_CYC
        && (st.policy == POL_AUTO || ackEvent)) begin
      next_st.faultDevice = 1'b0;
    end
    if ((st.faultOverload && !next_st.faultOverload)
        || (st.faultDevice && !next_st.faultDevice)) begin
      evt[`IRQ_CLEARED] = 1'b1;
      next_st.autoCnt = '0;
    end

    // new trips latch and restart the timer
    if (overloadTrip && !st.faultOverload) begin
      next_st.faultOverload = 1'b1;
      next_st.autoCnt = '0;
      evt[`IRQ_TRIP] = 1'b1;
    end
    if (deviceTrip && !st.faultDevice) begin
      next_st.faultDevice = 1'b1;
      next_st.autoCnt = '0;
      evt[`IRQ_TRIP] = 1'b1;
    end
    faultAny = st.faultOverload || st.faultDevice;

    // motor sequence
    case (st.motor)
      MOT_OFF: begin
        if (startLvl && !faultAny) begin
          next_st.motor = MOT_RAMP;
        end
      end
      MOT_RAMP: begin
        if (faultAny) begin
          next_st.motor = MOT_OFF;
        end else if (!startLvl) begin
          next_st.motor = st.rampDownEn ? MOT_STOP : MOT_OFF;
        end else if (rampUpDone) begin
          next_st.motor = MOT_BYPASS;
          evt[`IRQ_BYPASS] = 1'b1;
        end
      end
      MOT_BYPASS: begin
        if (faultAny) begin
          next_st.motor = MOT_OFF;
        end else if (!startLvl) begin
          next_st.motor = st.rampDownEn ? MOT_STOP : MOT_OFF;
        end
      end
      default: begin
        if (faultAny || rampDownDone) begin
          next_st.motor = MOT_OFF;
        end else if (startLvl) begin
          next_st.motor = MOT_RAMP;
        end
      end
    endcase

    // APB slave: access phase with one wait state, answer registered
    apbAccess = psel && penable && !st.pready;
    next_st.prdata = '0;
    if (apbAccess) begin
      next_st.pready = 1'b1;
      if (paddr == `OFF_CTRL) begin
        if (pwrite) begin
          next_st.rampDownEn = pwdata[`CTRL_RAMPDOWN_EN];
          next_st.runMode = pwdata[`CTRL_FORCE_RUNMODE];
        end else begin
          next_st.prdata[`CTRL_RAMPDOWN_EN] = st.rampDownEn;
          next_st.prdata[`CTRL_FORCE_RUNMODE] = st.runMode;
        end
      end else if (paddr == `OFF_STATUS) begin
        next_st.prdata[1:0] = st.motor;
        next_st.prdata[3:2] = st.policy;
        next_st.prdata[4] = startLvl;
      end else if (paddr == `OFF_IRQ_STAT) begin
        next_st.prdata[`IRQ_WIDTH-1:0] = st.irqStat;
        if (!pwrite) begin
          next_st.irqStat = '0;
        end
      end else if (paddr == `OFF_IRQ_MASK) begin
        if (pwrite) begin
          next_st.irqMask = pwdata[`IRQ_WIDTH-1:0];
        end else begin
          next_st.prdata[`IRQ_WIDTH-1:0] = st.irqMask;
        end
      end else if (paddr == `OFF_FAULT) begin
        next_st.prdata[0] = st.faultOverload;
        next_st.prdata[1] = st.faultDevice;
      end else begin
        next_st.pslverr = 1'b1;
      end
    end
    // events set after the read clear, so a same-cycle event is kept
    next_st.irqStat = next_st.irqStat | evt;

    // contacts, all registered
    next_st.motorOn = (next_st.motor != MOT_OFF);
    next_st.softStop = (next_st.motor == MOT_STOP);
    if (next_st.runMode) begin
      next_st.echoContact = (next_st.motor != MOT_OFF);
    end else begin
      next_st.echoContact = startLvl;
    end
    next_st.bypassedContact = (next_st.motor == MOT_BYPASS);
    next_st.bypassRelay = (next_st.motor == MOT_BYPASS);
    next_st.groupFaultContact = next_st.faultOverload || next_st.faultDevice;
    next_st.overloadLed = next_st.faultOverload;
    next_st.policyLed = (next_st.policy == POL_AUTO);
    next_st.irq = |(next_st.irqStat & next_st.irqMask);
  end

  // =====================================================================
  // single state register; supply loss resets it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.policy <= POL_MANUAL;
      st.motor <= MOT_OFF;
      st.groupFaultContact <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign echoContact = st.echoContact;
  assign bypassedContact = st.bypassedContact;
  assign bypassRelay = st.bypassRelay;
  assign groupFaultContact = st.groupFaultContact;
  assign overloadLed = st.overloadLed;
  assign policyLed = st.policyLed;
  assign motorOn = st.motorOn;
  assign softStop = st.softStop;
  assign irq = st.irq;

endmodule

// [verif/supervisor_properties.sv]
/*
  Port-level checks of the soft starter supervisor.
  Assumes it is bound into motor_supervisor; one clock, async low reset.
*/
`timescale 1ns/1ps
module supervisor_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic overloadTrip,
  input wire logic rampDownDone,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic bypassedContact,
  input wire logic bypassRelay,
  input wire logic groupFaultContact,
  input wire logic overloadLed,
  input wire logic motorOn,
  input wire logic softStop
);
  // =====================================================================
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_apb_answer:
    assert property (psel && penable && !pready |=> pready) else $error("apb answer late");
  a_pready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
  a_bypass_pair:
    assert property (bypassedContact == bypassRelay) else $error("bypass outputs split");
  a_bypass_running:
    assert property (bypassRelay |-> motorOn) else $error("bypass without motor");
  a_overload_contact:
    assert property (overloadLed |-> groupFaultContact) else $error("overload without fault");
  a_trip_contact:
    assert property ($rose(overloadTrip) |-> ##[1:3] groupFaultContact) else $error("trip unseen");
  a_trip_stops_motor:
    assert property ($rose(overloadLed) |-> ##[0:3] !motorOn) else $error("motor kept on");
  a_soft_stop_end:
    assert property (softStop && rampDownDone |=> ##[0:1] !softStop) else $error("stop stuck");
endmodule

bind motor_supervisor supervisor_properties u_props (.*);

// [verif/start_controller.sv]
/*
  Model of the external controller and pushbuttons at the start input side.
  Assumes the bench calls its tasks from a single thread.
*/
`timescale 1ns/1ps
module start_controller (
  input wire logic mclk,
  output logic startPin,
  output logic ackKeyPin,
  output logic policyKeyPin,
  output logic remoteAckPin
);
  // =====================================================================
  // pin drivers
  // a released button reads open, so every pin rests low
  initial begin
    startPin = 1'h0;
    ackKeyPin = 1'h0;
    policyKeyPin = 1'h0;
    remoteAckPin = 1'h0;
  end

  task setStart(input logic v);
    @(posedge mclk);
    startPin <= v;
  endtask

  // keys held for cyc edges, then a gap so the synchroniser sees the release
  task press(input logic ack, input logic pol, input int cyc);
    @(posedge mclk);
    ackKeyPin <= ack;
    policyKeyPin <= pol;
    repeat (cyc) @(posedge mclk);
    ackKeyPin <= 1'h0;
    policyKeyPin <= 1'h0;
    repeat (4) @(posedge mclk);
  endtask

  // start dropped first so the clear cannot restart the motor
  task acknowledge();
    setStart(1'h0);
    repeat (4) @(posedge mclk);
    press(1'h1, 1'h0, 5);
  endtask

  task remoteAck();
    @(posedge mclk);
    remoteAckPin <= 1'h1;
    repeat (5) @(posedge mclk);
    remoteAckPin <= 1'h0;
  endtask
endmodule

// [verif/test_motor_supervisor.sv]
/*
  Self-checking bench of motor_supervisor with shortened timers.
  Assumes start_controller drives the pins and the checker is bound.
*/
`timescale 1ns/1ps
`include "starter_params.svh"
module test_motor_supervisor;
  logic mclk, rst_n, overloadTrip, deviceTrip, rampUpDone, rampDownDone;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic startPin, ackKeyPin, policyKeyPin, remoteAckPin, policyLed, irq;
  logic echoContact, bypassedContact, bypassRelay, groupFaultContact, overloadLed;
  logic motorOn, softStop;
  int miscompares, tests_run, waited;

  motor_supervisor #(.OVERLOAD_CYC(200), .DEVICE_CYC(100), .TEST_CYC(50), .SHORT_CYC(20))
    DUT (.*);
  start_controller ctl (.*);

  // =====================================================================
  // helpers
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded wait; a hang counts as a mismatch and ends the run
  task automatic waitSig(ref logic s, input logic v, input int n);
    waited = 0;
    while (s !== v && waited < n) begin
      @(posedge mclk);
      waited++;
    end
    if (s !== v) begin
      $display("Error wait expected %b seen %b", v, s);
      miscompares++;
      summarize();
    end
  endtask

  // one-cycle pulse: 0 overload trip, 1 device trip, 2 ramp-up done, 3 ramp-down done
  task automatic pulse(input int which);
    logic lvl;
    lvl = 1'h1;
    repeat (2) begin
      @(posedge mclk);
      if (which == 0) overloadTrip <= lvl;
      else if (which == 1) deviceTrip <= lvl;
      else if (which == 2) rampUpDone <= lvl;
      else rampDownDone <= lvl;
      lvl = ~lvl;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      $display("Error apb pready expected 1 seen %b", pready);
      miscompares++;
      summarize();
    end
  endtask

  // =====================================================================
  // stimulus
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    {rst_n, overloadTrip, deviceTrip, rampUpDone, rampDownDone, psel, penable, pwrite} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    // registers: reset policy, mask, refused address, soft stop enable
    apb(1'h0, `OFF_STATUS, 32'h0);
    chk("status", rd, 32'h4);
    apb(1'h1, `OFF_IRQ_MASK, 32'h7);
    apb(1'h0, `OFF_IRQ_MASK, 32'h0);
    chk("mask", rd, 32'h7);
    apb(1'h0, 12'h020, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    apb(1'h1, `OFF_CTRL, 32'h1);
    // start, ramp-up, bypass, soft stop
    ctl.setStart(1'h1);
    waitSig(echoContact, 1'h1, 10);
    chk("motorOn", 32'(motorOn), 32'h1);
    pulse(2);
    waitSig(bypassRelay, 1'h1, 10);
    chk("bypassed", 32'(bypassedContact), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    apb(1'h0, `OFF_IRQ_STAT, 32'h0);
    chk("irqStat", rd, 32'h4);
    repeat (2) @(posedge mclk);
    chk("irqClear", 32'(irq), 32'h0);
    ctl.setStart(1'h0);
    waitSig(softStop, 1'h1, 10);
    chk("bypassOpen", 32'(bypassRelay), 32'h0);
    waitSig(echoContact, 1'h0, 10);
    pulse(3);
    waitSig(motorOn, 1'h0, 10);
    // manual policy: latched overload, recovery block, short press
    pulse(0);
    waitSig(groupFaultContact, 1'h1, 5);
    chk("overloadLed", 32'(overloadLed), 32'h1);
    apb(1'h0, `OFF_FAULT, 32'h0);
    chk("faultReg", rd, 32'h1);
    apb(1'h0, `OFF_IRQ_STAT, 32'h0);
    chk("irqTrip", rd, 32'h1);
    ctl.setStart(1'h1);
    repeat (6) @(posedge mclk);
    chk("blocked", 32'(motorOn), 32'h0);
    ctl.acknowledge();
    chk("recovery", 32'(groupFaultContact), 32'h1);
    repeat (200) @(posedge mclk);
    ctl.acknowledge();
    waitSig(groupFaultContact, 1'h0, 10);
    apb(1'h0, `OFF_IRQ_STAT, 32'h0);
    chk("irqCleared", rd, 32'h2);
    // remote policy
    ctl.press(1'h0, 1'h1, 5);
    apb(1'h0, `OFF_STATUS, 32'h0);
    chk("remote", 32'(rd[3:2]), 32'h2);
    chk("ledDark", 32'(policyLed), 32'h0);
    pulse(1);
    waitSig(groupFaultContact, 1'h1, 5);
    // device recovery time not yet over, so this acknowledge must not clear
    ctl.remoteAck();
    chk("deviceHold", 32'(groupFaultContact), 32'h1);
    repeat (100) @(posedge mclk);
    ctl.remoteAck();
    waitSig(groupFaultContact, 1'h0, 10);
    // auto policy: device delay, restart, trip test, overload delay
    ctl.press(1'h0, 1'h1, 5);
    waitSig(policyLed, 1'h1, 8);
    ctl.setStart(1'h1);
    waitSig(motorOn, 1'h1, 10);
    pulse(1);
    waitSig(groupFaultContact, 1'h1, 5);
    waitSig(groupFaultContact, 1'h0, 130);
    chk("deviceDelay", 32'(waited >= 95), 32'h1);
    waitSig(motorOn, 1'h1, 10);
    ctl.press(1'h1, 1'h0, 60);
    chk("testTrip", 32'(overloadLed), 32'h1);
    chk("testStop", 32'(motorOn), 32'h0);
    waitSig(groupFaultContact, 1'h0, 230);
    chk("overloadDelay", 32'(waited >= 150), 32'h1);
    waitSig(motorOn, 1'h1, 10);
    // both keys: motor active contact through soft stop
    ctl.press(1'h1, 1'h1, 5);
    apb(1'h0, `OFF_CTRL, 32'h0);
    chk("runMode", 32'(rd[1]), 32'h1);
    ctl.setStart(1'h0);
    waitSig(softStop, 1'h1, 10);
    repeat (5) @(posedge mclk);
    chk("runContact", 32'(echoContact), 32'h1);
    pulse(3);
    waitSig(echoContact, 1'h0, 10);
    // no ramp-down time: removal switches straight off, no soft stop
    apb(1'h1, `OFF_CTRL, 32'h0);
    ctl.setStart(1'h1);
    waitSig(motorOn, 1'h1, 10);
    ctl.setStart(1'h0);
    waitSig(motorOn, 1'h0, 10);
    chk("abruptStop", 32'(softStop), 32'h0);
    // supply loss with the motor stopped: fault position, motor off, policy back to manual
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    chk("supplyFault", 32'(groupFaultContact), 32'h1);
    chk("supplyMotor", 32'(motorOn), 32'h0);
    rst_n <= 1'h1;
    apb(1'h0, `OFF_STATUS, 32'h0);
    chk("resetStatus", rd, 32'h4);
    summarize();
  end
endmodule
